// File: verilog/two_wire_link_pkg.sv
// Shared constants and types for the two-wire frame access link
package two_wire_link_pkg;

  localparam int ADDR_W = 16;
  localparam int CNT_W  = 16;
  localparam int BUS_AW = 8;
  localparam int IRQ_W  = 3;
  localparam int SYNC_W = 6;

  // Register byte offsets, one aligned 32-bit word each
  localparam logic [BUS_AW-1:0] OFS_CH0_ADDR = 8'h00;
  localparam logic [BUS_AW-1:0] OFS_CH0_CNT  = 8'h04;
  localparam logic [BUS_AW-1:0] OFS_CH0_CTRL = 8'h08;
  localparam logic [BUS_AW-1:0] OFS_CH1_ADDR = 8'h0c;
  localparam logic [BUS_AW-1:0] OFS_CH1_CNT  = 8'h10;
  localparam logic [BUS_AW-1:0] OFS_CH1_CTRL = 8'h14;
  localparam logic [BUS_AW-1:0] OFS_PRIO     = 8'h18;
  localparam logic [BUS_AW-1:0] OFS_IRQ_STAT = 8'h1c;
  localparam logic [BUS_AW-1:0] OFS_IRQ_CLR  = 8'h20;
  localparam logic [BUS_AW-1:0] OFS_IRQ_EN   = 8'h24;
  localparam logic [BUS_AW-1:0] OFS_STATE    = 8'h28;

  // Field positions
  localparam int CTRL_DOWN_BIT  = 0;
  localparam int CTRL_MRD_BIT   = 1;
  localparam int CTRL_TSC_BIT   = 2;
  localparam int PRIO_CH0_BIT   = 0;
  localparam int PRIO_CH1_BIT   = 1;
  localparam int IRQ_CTS_LOST   = 0;
  localparam int IRQ_TX_DONE    = 1;
  localparam int IRQ_RX_END     = 2;

  // Synchroniser bit positions
  localparam int S_TXREQ = 0;
  localparam int S_RXREQ = 1;
  localparam int S_GRANT = 2;
  localparam int S_RTS   = 3;
  localparam int S_BCLK  = 4;
  localparam int S_RXEND = 5;

  // Reset values
  localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
  localparam logic [CNT_W-1:0]  CNT_RST  = 16'h0000;
  localparam logic [IRQ_W-1:0]  IRQ_RST  = 3'h0;

  // Bit-clock periods from request-to-send to clear-to-send
  localparam int CTS_DELAY_BITS = 32;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [CNT_W-1:0]  count;
    logic              down;
    logic              mem_read;
    logic              three_state_cycle_steal;
  } chan_cfg_t;

  typedef struct packed {
    logic cs;
    logic rw;
    logic rs1;
    logic rs0;
  } link_sel_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_REQ,
    ST_CYC1,
    ST_CYC2,
    ST_GAP
  } access_state_t;

endpackage

// File: verilog/pin_sync.sv
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module pin_sync
#(
  parameter int W = 1
)
(
  input  wire logic         ref_clk_i,
  input  wire logic         resetn_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta;

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      meta   <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end

endmodule

// File: verilog/cts_delay.sv
// Modem clear-to-send delay and end-of-block drop
`timescale 1ns/1ps
module cts_delay
  import two_wire_link_pkg::*;
(
  input  wire logic ref_clk_i,
  input  wire logic resetn_i,
  input  wire logic rts_i,
  input  wire logic bit_tick_i,
  input  wire logic eob_i,
  output logic      cts_o
);

  logic [5:0] bits;
  logic       blocked;

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      bits    <= 6'h00;
      blocked <= 1'b0;
      cts_o   <= 1'b0;
    end
    else if (!rts_i)
    begin
      bits    <= 6'h00;
      blocked <= 1'b0;
      cts_o   <= 1'b0;
    end
    else if (eob_i)
    begin
      // Stays low until request-to-send is dropped and raised again
      blocked <= 1'b1;
      cts_o   <= 1'b0;
    end
    else if (!blocked && !cts_o && bit_tick_i)
    begin
      if (bits == 6'(CTS_DELAY_BITS - 1))
        cts_o <= 1'b1;
      else
        bits <= bits + 6'h01;
    end
  end

endmodule

// File: verilog/two_wire_frame_dma_link.sv
// Two-channel memory access sequencer for the two-wire frame link
//
// Decided for this implementation: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
module two_wire_frame_dma_link
  import two_wire_link_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic              resetn_i,
  // Avalon-MM slave
  input  wire logic [BUS_AW-1:0] address_i,
  input  wire logic              read_i,
  input  wire logic              write_i,
  input  wire logic [31:0]       writedata_i,
  output logic      [31:0]       readdata_o,
  output logic                   waitrequest_o,
  output logic                   irq_o,
  // Link controller and timing logic pins
  input  wire logic              tx_service_request_i,
  input  wire logic              rx_service_request_i,
  input  wire logic              access_grant_i,
  input  wire logic              rts_i,
  input  wire logic              bit_clk_i,
  input  wire logic              rx_terminate_i,
  output logic                   access_request_o,
  output logic                   channel_a_acknowledge_o,
  output logic                   access_cycle_strobe_o,
  output logic                   end_of_block_o,
  output logic                   memory_access_mode_o,
  output logic                   addr_drive_en_o,
  output logic      [ADDR_W-1:0] mem_addr_o,
  output logic                   mem_read_o,
  output link_sel_t              link_sel_o,
  output logic                   cts_o
);

  logic [SYNC_W-1:0] pins;
  access_state_t     state;
  access_state_t     next_state;
  logic              chan;
  logic              next_chan;
  chan_cfg_t         cfg0;
  chan_cfg_t         cfg1;
  chan_cfg_t         cur;
  logic              en0;
  logic              en1;
  logic [IRQ_W-1:0]  irq_stat;
  logic [IRQ_W-1:0]  irq_en;
  logic [IRQ_W-1:0]  events;
  logic              bclk_q;
  logic              rxend_q;
  logic              cts;
  logic              cts_q;
  logic              tx_ok;
  logic              rx_ok;
  logic              eob_tx;
  logic              bus_req;
  logic              wr_en;
  logic [31:0]       rd_val;

  pin_sync #(.W(SYNC_W)) u_sync
  (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .async_i   ({rx_terminate_i, bit_clk_i, rts_i, access_grant_i,
                 rx_service_request_i, tx_service_request_i}),
    .sync_o    (pins)
  );
  cts_delay u_cts
  (
    .ref_clk_i  (ref_clk_i),
    .resetn_i   (resetn_i),
    .rts_i      (pins[S_RTS]),
    .bit_tick_i (pins[S_BCLK] && !bclk_q),
    .eob_i      (eob_tx),
    .cts_o      (cts)
  );

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      bclk_q  <= 1'b0;
      rxend_q <= 1'b0;
      cts_q   <= 1'b0;
      cts_o   <= 1'b0;
    end
    else
    begin
      bclk_q  <= pins[S_BCLK];
      rxend_q <= pins[S_RXEND];
      cts_q   <= cts;
      cts_o   <= cts;
    end
  end

  assign cur    = chan ? cfg1 : cfg0;
  assign eob_tx = (state == ST_CYC2) && !chan &&
                  (cur.count == 16'h0001);
  // Transmit request is ignored until the modem answers clear-to-send
  assign tx_ok  = en0 && cts && pins[S_TXREQ] &&
                  (cfg0.count != CNT_RST);
  assign rx_ok  = en1 && pins[S_RXREQ] &&
                  (cfg1.count != CNT_RST);
  always_comb
  begin
    next_state = state;
    next_chan  = chan;
    case (state)
      ST_IDLE:
      begin
        if (tx_ok)
        begin
          next_state = ST_REQ;
          next_chan  = 1'b0;
        end
        else if (rx_ok)
        begin
          next_state = ST_REQ;
          next_chan  = 1'b1;
        end
      end
      ST_REQ:
        if (pins[S_GRANT])
          next_state = ST_CYC1;
      ST_CYC1:
        next_state = ST_CYC2;
      ST_CYC2:
        next_state = ST_GAP;
      // Wait for the request to fall so one request moves one byte
      ST_GAP:
        if (!(chan ? pins[S_RXREQ] : pins[S_TXREQ]))
          next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state <= ST_IDLE;
      chan  <= 1'b0;
    end
    else
    begin
      state <= next_state;
      chan  <= next_chan;
    end
  end

  // Pin outputs, registered from the next state
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      access_request_o        <= 1'b0;
      channel_a_acknowledge_o <= 1'b1;
      access_cycle_strobe_o   <= 1'b0;
      end_of_block_o          <= 1'b0;
      memory_access_mode_o    <= 1'b0;
      addr_drive_en_o         <= 1'b0;
      mem_addr_o              <= ADDR_RST;
      mem_read_o              <= 1'b0;
      link_sel_o              <= '0;
    end
    else
    begin
      access_request_o <= (next_state == ST_REQ) ||
                          (next_state == ST_CYC1) ||
                          (next_state == ST_CYC2);
      // Low only while a channel 0 access is in progress
      channel_a_acknowledge_o <= !(!next_chan &&
                                   (next_state == ST_CYC1 ||
                                    next_state == ST_CYC2));
      access_cycle_strobe_o <= (next_state == ST_CYC2);
      memory_access_mode_o  <= (next_state == ST_CYC2);
      addr_drive_en_o       <= (next_state == ST_CYC2);
      end_of_block_o <= (next_state == ST_CYC2) &&
                        (cur.count == 16'h0001);
      if (next_state == ST_CYC2)
      begin
        mem_addr_o <= cur.addr;
        mem_read_o <= cur.mem_read;
      end
      link_sel_o.cs  <= (next_state == ST_CYC2);
      link_sel_o.rw  <= (next_state == ST_CYC2) && next_chan;
      link_sel_o.rs1 <= (next_state == ST_CYC2);
      // Last byte of either channel, transmit or receive, goes to the frame-terminate register
      link_sel_o.rs0 <= (next_state == ST_CYC2) &&
                        (cur.count == 16'h0001);
    end
  end
  assign bus_req = read_i || write_i;
  assign wr_en   = write_i && !waitrequest_o;
  // Channel registers; the cycle-two address and count update wins over a software write in the same cycle
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cfg0 <= '{addr: ADDR_RST, count: CNT_RST, default: 1'b0};
      cfg1 <= '{addr: ADDR_RST, count: CNT_RST, default: 1'b0};
    end
    else
    begin
      if (wr_en)
      begin
        if (address_i == OFS_CH0_ADDR)
          cfg0.addr <= writedata_i[ADDR_W-1:0];
        else if (address_i == OFS_CH0_CNT)
          cfg0.count <= writedata_i[CNT_W-1:0];
        else if (address_i == OFS_CH0_CTRL)
          {cfg0.three_state_cycle_steal, cfg0.mem_read, cfg0.down} <= writedata_i[2:0];
        else if (address_i == OFS_CH1_ADDR)
          cfg1.addr <= writedata_i[ADDR_W-1:0];
        else if (address_i == OFS_CH1_CNT)
          cfg1.count <= writedata_i[CNT_W-1:0];
        else if (address_i == OFS_CH1_CTRL)
          {cfg1.three_state_cycle_steal, cfg1.mem_read, cfg1.down} <= writedata_i[2:0];
      end
      if (state == ST_CYC2)
      begin
        if (!chan)
        begin
          cfg0.addr  <= cfg0.down ? cfg0.addr - 16'h0001
                                  : cfg0.addr + 16'h0001;
          cfg0.count <= cfg0.count - 16'h0001;
        end
        else
        begin
          cfg1.addr  <= cfg1.down ? cfg1.addr - 16'h0001
                                  : cfg1.addr + 16'h0001;
          cfg1.count <= cfg1.count - 16'h0001;
        end
      end
    end
  end

  // Request enables; a receive end event switches channel 1 off
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      en0 <= 1'b0;
      en1 <= 1'b0;
    end
    else
    begin
      if (wr_en && address_i == OFS_PRIO)
      begin
        en0 <= writedata_i[PRIO_CH0_BIT];
        en1 <= writedata_i[PRIO_CH1_BIT];
      end
      if (pins[S_RXEND] && !rxend_q)
        en1 <= 1'b0;
    end
  end

  assign events[IRQ_CTS_LOST] = cts_q && !cts;
  assign events[IRQ_TX_DONE]  = eob_tx;
  assign events[IRQ_RX_END]   = pins[S_RXEND] && !rxend_q;
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      irq_stat <= IRQ_RST;
      irq_en   <= IRQ_RST;
      irq_o    <= 1'b0;
    end
    else
    begin
      // A new event wins over a clear in the same cycle
      if (wr_en && address_i == OFS_IRQ_CLR)
        irq_stat <= (irq_stat & ~writedata_i[IRQ_W-1:0]) | events;
      else
        irq_stat <= irq_stat | events;
      if (wr_en && address_i == OFS_IRQ_EN)
        irq_en <= writedata_i[IRQ_W-1:0];
      irq_o <= |(irq_stat & irq_en);
    end
  end

  always_comb
  begin
    rd_val = 32'h0000_0000;
    if (address_i == OFS_CH0_ADDR)
      rd_val[ADDR_W-1:0] = cfg0.addr;
    else if (address_i == OFS_CH0_CNT)
      rd_val[CNT_W-1:0] = cfg0.count;
    else if (address_i == OFS_CH0_CTRL)
      rd_val[2:0] = {cfg0.three_state_cycle_steal, cfg0.mem_read, cfg0.down};
    else if (address_i == OFS_CH1_ADDR)
      rd_val[ADDR_W-1:0] = cfg1.addr;
    else if (address_i == OFS_CH1_CNT)
      rd_val[CNT_W-1:0] = cfg1.count;
    else if (address_i == OFS_CH1_CTRL)
      rd_val[2:0] = {cfg1.three_state_cycle_steal, cfg1.mem_read, cfg1.down};
    else if (address_i == OFS_PRIO)
      rd_val[1:0] = {en1, en0};
    else if (address_i == OFS_IRQ_STAT)
      rd_val[IRQ_W-1:0] = irq_stat;
    else if (address_i == OFS_IRQ_EN)
      rd_val[IRQ_W-1:0] = irq_en;
    else if (address_i == OFS_STATE)
      rd_val[3:0] = {chan, (state != ST_IDLE), pins[S_RTS], cts};
  end
  // One wait cycle per access; data and write effect at the low edge
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      waitrequest_o <= 1'b1;
      readdata_o    <= 32'h0000_0000;
    end
    else if (bus_req && waitrequest_o)
    begin
      waitrequest_o <= 1'b0;
      readdata_o    <= read_i ? rd_val : 32'h0000_0000;
    end
    else
      waitrequest_o <= 1'b1;
  end
endmodule

// File: tb/two_wire_frame_dma_link_props.sv
// Port checker for the two-wire frame access link
`timescale 1ns/1ps
module link_props
  import two_wire_link_pkg::*;
(
  input  wire logic      ref_clk_i,
  input  wire logic      resetn_i,
  input  wire logic      read_i,
  input  wire logic      write_i,
  input  wire logic      waitrequest_o,
  input  wire logic      rts_i,
  input  wire logic      bit_clk_i,
  input  wire logic      access_request_o,
  input  wire logic      channel_a_acknowledge_o,
  input  wire logic      access_cycle_strobe_o,
  input  wire logic      end_of_block_o,
  input  wire logic      memory_access_mode_o,
  input  wire logic      addr_drive_en_o,
  input  wire link_sel_t link_sel_o,
  input  wire logic      cts_o
);
  logic       bclk_q;
  logic [7:0] ticks;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  // Bit ticks seen while request-to-send is up; sync lag allows up to 34
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      bclk_q <= 1'b0;
      ticks  <= 8'h00;
    end
    else
    begin
      bclk_q <= bit_clk_i;
      if (!rts_i)
        ticks <= 8'h00;
      else if (bit_clk_i && !bclk_q && ticks != 8'hff)
        ticks <= ticks + 8'h01;
    end
  end

  a_cts_after_bits: assert property (
    $rose(cts_o) |-> ticks >= 8'h20 && ticks <= 8'h22)
    else $error("clear-to-send rose at wrong tick count");
  a_cycle_two_group: assert property (
    access_cycle_strobe_o |-> memory_access_mode_o && addr_drive_en_o
      && link_sel_o.cs && link_sel_o.rs1 && access_request_o)
    else $error("cycle two outputs incomplete");
  a_sel_idle: assert property (
    !access_cycle_strobe_o |-> link_sel_o == 4'h0 && !memory_access_mode_o)
    else $error("selects active outside cycle two");
  a_rs0_from_eob: assert property (
    access_cycle_strobe_o |-> link_sel_o.rs0 == end_of_block_o)
    else $error("low select differs from end of block");
  a_eob_in_cycle: assert property (
    end_of_block_o |-> access_cycle_strobe_o)
    else $error("end of block outside an access cycle");
  a_ack_gives_rw: assert property (
    access_cycle_strobe_o |-> link_sel_o.rw == channel_a_acknowledge_o)
    else $error("acknowledge and read-write disagree");
  a_ack_then_strobe: assert property (
    $fell(channel_a_acknowledge_o) |=> access_cycle_strobe_o)
    else $error("cycle one not followed by strobe");
  a_cycle_ends: assert property (
    access_cycle_strobe_o |=> !access_request_o && channel_a_acknowledge_o
      && !access_cycle_strobe_o)
    else $error("access not closed after cycle two");
  a_req_before_strobe: assert property (
    $rose(access_cycle_strobe_o) |-> $past(access_request_o, 2))
    else $error("strobe without prior access request");
  a_eob_drops_cts: assert property (
    end_of_block_o && !link_sel_o.rw |-> ##[1:3] !cts_o)
    else $error("clear-to-send kept after end of block");
  a_bus_answer: assert property (
    (read_i || write_i) && waitrequest_o |=> !waitrequest_o)
    else $error("bus access not answered next cycle");
  a_wait_one: assert property (!waitrequest_o |=> waitrequest_o)
    else $error("waitrequest low for more than one cycle");

  c_tx_last: cover property (end_of_block_o && !link_sel_o.rw);
  c_rx_byte: cover property (access_cycle_strobe_o && link_sel_o.rw);
  c_cts_up: cover property ($rose(cts_o));
endmodule

bind two_wire_frame_dma_link link_props u_props (.*);

// File: tb/link_side_model.sv
// Link controller and timing logic stand-in for the access link
`timescale 1ns/1ps
module link_side_model
(
  input  wire logic       ref_clk_i,
  input  wire logic       resetn_i,
  input  wire logic       tx_on_i,
  input  wire logic       rx_on_i,
  input  wire logic [3:0] gap_i,
  input  wire logic       access_request_i,
  input  wire logic       access_cycle_strobe_i,
  output logic            tx_service_request_o,
  output logic            rx_service_request_o,
  output logic            access_grant_o
);
  logic [3:0] wait_cnt;
  logic [3:0] gnt_cnt;

  // Grant lags the request by the gap, so slow timing logic is seen
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      access_grant_o <= 1'b0;
      gnt_cnt        <= 4'h0;
    end
    else if (!access_request_i)
    begin
      access_grant_o <= 1'b0;
      gnt_cnt        <= gap_i;
    end
    else if (gnt_cnt != 4'h0)
      gnt_cnt <= gnt_cnt - 4'h1;
    else
      access_grant_o <= 1'b1;
  end

  // Requests ignore clear-to-send; gating is left to the block
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      tx_service_request_o <= 1'b0;
      rx_service_request_o <= 1'b0;
      wait_cnt             <= 4'h0;
    end
    else if (access_cycle_strobe_i)
    begin
      tx_service_request_o <= 1'b0;
      rx_service_request_o <= 1'b0;
      wait_cnt             <= gap_i;
    end
    else if (wait_cnt != 4'h0)
      wait_cnt <= wait_cnt - 4'h1;
    else
    begin
      // One request per 8-bit word, as a transmitter in access mode
      tx_service_request_o <= tx_on_i;
      rx_service_request_o <= rx_on_i;
    end
  end
endmodule

// File: tb/tb_two_wire_frame_dma_link.sv
// Self-checking bench for the two-wire frame access link
`timescale 1ns/1ps
module tb_two_wire_frame_dma_link
  import two_wire_link_pkg::*;
;
  typedef struct packed
  {
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] q;
  } row_t;

  logic              ref_clk_i, resetn_i, read_i, write_i, rts_i;
  logic [BUS_AW-1:0] address_i;
  logic [31:0]       writedata_i, readdata_o, rd;
  logic              waitrequest_o, irq_o, tx_service_request_i;
  logic              rx_service_request_i, access_grant_i, bit_clk_i;
  logic              rx_terminate_i, access_request_o, cts_o;
  logic              channel_a_acknowledge_o, access_cycle_strobe_o;
  logic              end_of_block_o, memory_access_mode_o;
  logic              addr_drive_en_o, mem_read_o, tx_on, rx_on;
  logic [ADDR_W-1:0] mem_addr_o;
  link_sel_t         link_sel_o;
  logic [3:0]        gap;
  logic [1:0]        bcnt = 2'h0;
  int                n_errors, check_count, n_early;
  logic [ADDR_W-1:0] seen_addr [$];
  logic [2:0]        seen_flag [$];
  row_t              rows [7] = '{
    '{OFS_CH0_ADDR, 32'h00001234, 32'h00001234},
    '{OFS_CH0_CNT, 32'h0005ffff, 32'h0000ffff},
    '{OFS_CH0_CTRL, 32'h0000000f, 32'h00000007},
    '{OFS_CH1_ADDR, 32'h0000abcd, 32'h0000abcd},
    '{OFS_IRQ_EN, 32'h00000005, 32'h00000005},
    '{OFS_IRQ_STAT, 32'h00000007, 32'h00000000},
    '{8'h2c, 32'hffffffff, 32'h00000000}};

  two_wire_frame_dma_link dut (.*);

  link_side_model u_far (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .tx_on_i(tx_on),
    .rx_on_i(rx_on), .gap_i(gap), .access_request_i(access_request_o),
    .access_cycle_strobe_i(access_cycle_strobe_o),
    .tx_service_request_o(tx_service_request_i),
    .rx_service_request_o(rx_service_request_i),
    .access_grant_o(access_grant_i));

  initial
  begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  // Modem bit clock, one tick every four cycles
  assign bit_clk_i = bcnt[1];
  always @(posedge ref_clk_i)
    bcnt <= bcnt + 2'h1;

  always @(posedge ref_clk_i)
    if (resetn_i && access_cycle_strobe_o === 1'b1)
    begin
      seen_addr.push_back(mem_addr_o);
      seen_flag.push_back({link_sel_o.rw, end_of_block_o,
                           channel_a_acknowledge_o});
      if (cts_o !== 1'b1 && !link_sel_o.rw)
        n_early++;
    end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    address_i   <= a;
    writedata_i <= d;
    write_i     <= wr;
    read_i      <= !wr;
    @(posedge ref_clk_i);
    // No own limit: only the watchdog ends a stuck access
    while (waitrequest_o !== 1'b0)
      @(posedge ref_clk_i);
    rd = readdata_o;
    write_i <= 1'b0;
    read_i  <= 1'b0;
    @(posedge ref_clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] q);
    bus(1'b0, a, 32'h0);
    check(rd, q);
  endtask

  task automatic reset_check();
    check({waitrequest_o, channel_a_acknowledge_o, access_request_o,
      access_cycle_strobe_o, end_of_block_o, memory_access_mode_o,
      addr_drive_en_o, cts_o, irq_o, link_sel_o, mem_addr_o},
      32'h18000000);
  endtask

  task automatic complete_run();
    if (n_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge ref_clk_i);
    n_errors++;
    complete_run();
  end

  initial
  begin
    resetn_i = 1'b0;
    read_i = 1'b0;
    write_i = 1'b0;
    address_i = '0;
    writedata_i = '0;
    rts_i = 1'b0;
    rx_terminate_i = 1'b0;
    tx_on = 1'b0;
    rx_on = 1'b0;
    gap = 4'h4;
    repeat (4) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    @(posedge ref_clk_i);
    reset_check();
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rdchk(rows[i].a, rows[i].q);
    end
    // Transmit three bytes upward with a slow grant
    wr(OFS_CH0_ADDR, 32'h00000100);
    wr(OFS_CH0_CNT, 32'h00000003);
    wr(OFS_CH0_CTRL, 32'h00000006);
    wr(OFS_IRQ_EN, 32'h00000007);
    wr(OFS_PRIO, 32'h00000001);
    tx_on <= 1'b1;
    gap <= 4'h9;
    rts_i <= 1'b1;
    for (int i = 0; i < 400 && cts_o !== 1'b1; i++) @(posedge ref_clk_i);
    check(cts_o, 1'b1);
    for (int i = 0; i < 900 && irq_o !== 1'b1; i++) @(posedge ref_clk_i);
    repeat (40) @(posedge ref_clk_i);
    check(seen_addr.size(), 3);
    check(n_early, 0);
    for (int i = 0; i < 3; i++)
    begin
      check(seen_addr[i], 16'h0100 + 16'(i));
      check(seen_flag[i], {1'b0, i == 2, 1'b0});
    end
    check(mem_read_o, 1'b1);
    check(cts_o, 1'b0);
    check(irq_o, 1'b1);
    rdchk(OFS_IRQ_STAT, 32'h00000003);
    rdchk(OFS_CH0_CNT, 32'h00000000);
    rdchk(OFS_CH0_ADDR, 32'h00000103);
    rdchk(OFS_STATE, 32'h00000002);
    wr(OFS_IRQ_CLR, 32'h00000003);
    rts_i <= 1'b0;
    tx_on <= 1'b0;
    rdchk(OFS_IRQ_STAT, 32'h00000000);
    check(irq_o, 1'b0);
    // Receive two bytes downward, then end with the interrupt masked
    seen_addr.delete();
    seen_flag.delete();
    wr(OFS_CH1_ADDR, 32'h00000200);
    wr(OFS_CH1_CNT, 32'h00000002);
    wr(OFS_CH1_CTRL, 32'h00000001);
    wr(OFS_PRIO, 32'h00000002);
    wr(OFS_IRQ_EN, 32'h00000003);
    rx_on <= 1'b1;
    gap <= 4'h4;
    for (int i = 0; i < 400 && seen_addr.size() < 2; i++)
      @(posedge ref_clk_i);
    repeat (30) @(posedge ref_clk_i);
    check(seen_addr.size(), 2);
    for (int i = 0; i < 2; i++)
    begin
      check(seen_addr[i], 16'h0200 - 16'(i));
      check(seen_flag[i], {1'b1, i == 1, 1'b1});
    end
    check(mem_read_o, 1'b0);
    rx_terminate_i <= 1'b1;
    rx_on <= 1'b0;
    repeat (6) @(posedge ref_clk_i);
    check(irq_o, 1'b0);
    rdchk(OFS_IRQ_STAT, 32'h00000004);
    rdchk(OFS_PRIO, 32'h00000000);
    wr(OFS_IRQ_EN, 32'h00000007);
    repeat (2) @(posedge ref_clk_i);
    check(irq_o, 1'b1);
    wr(OFS_IRQ_CLR, 32'h00000004);
    rx_terminate_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    check(irq_o, 1'b0);
    // Second reset in mid-run
    resetn_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    @(posedge ref_clk_i);
    reset_check();
    rdchk(OFS_CH1_ADDR, 32'h00000000);
    complete_run();
  end
endmodule
